// ===== hdl/acd_pkg.sv
// Package of constants and types for the axis command word decoder
// Function
// - Slide stop decelerates the axis at the current local or global rate.
// - After slide stop completes set done; in-position follows the band.
// - Slide stop works in both modes, beats setpoints, never flags loop fault.
// - Enhancement set keeps axis still in slide stop; clear still takes setpoints.
// - Immediate stop zeroes analog output and raises output 2 if fault output.
// - Immediate stop holds until a reset request or power cycle.
// - Immediate stop works in both modes and beats every other request.
// - Reset returns the loop to power-up state, beats setpoints and jogs.
// - Reset stops a moving axis first, then sets ready.
// - After reset the axis stays disabled until new parameters; other axis untouched.
// - Reset keeps programmable output configuration unchanged.
// - Integral disable freezes integral term; release resumes from held value.
// - Two-bit readout select picks position, following error or diagnostics.
// - Top two bits of a control word identify which word it is; the code checks them (01) on control word one only.
// - Low seven bits of control word two give the next target number.
// - Target zero or the present target leaves motion unchanged.
// - Target opposite to travel stops at current rate before reversing.
// - A new target waits for a hardware or software start.
// - Targets one to twelve use the setpoint block, thirteen the command block.
// - Setpoint 13 words keep the same format as setpoint block entries.
// - Rising start bit launches the move named in control word two.
package acd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CMD1 = 8'h00;
    localparam logic [7:0] ADR_CMD2 = 8'h04;
    localparam logic [7:0] ADR_SP13 = 8'h08;
    localparam logic [7:0] ADR_CFG  = 8'h1C;
    localparam logic [7:0] ADR_STAT = 8'h20;
    localparam logic [7:0] ADR_RD3  = 8'h24;
    localparam logic [7:0] ADR_RD4  = 8'h28;
    localparam int         SP13_WORDS = 5;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int B_START = 0;
    localparam int B_HWEN  = 1;
    localparam int B_AUTO  = 2;
    localparam int B_INC13 = 3;
    localparam int B_SLIDE = 7;
    localparam int B_ISTOP = 8;
    localparam int B_RESET = 9;
    localparam int B_IDIS  = 10;
    localparam int RSEL_LSB = 12;
    localparam int RSEL_MSB = 13;
    localparam int ID_LSB  = 14;
    localparam int ID_MSB  = 15;
    localparam int TGT_W   = 7;
    localparam logic [15:0] CMD1_MASK = 16'hF7FF;
    localparam logic [15:0] CMD2_MASK = 16'h007F;
    localparam logic [1:0]  CW1_ID    = 2'h1;
    localparam logic [1:0]  RSEL_POS  = 2'h0;
    localparam logic [1:0]  RSEL_FERR = 2'h1;
    localparam logic [6:0]  TGT_NONE  = 7'h00;
    localparam logic [6:0]  TGT_SP13  = 7'h0D;
    localparam int C_ENH   = 0;
    localparam int C_O2FLT = 1;
    localparam int C_O1PRG = 2;
    localparam int C_O2PRG = 3;
    localparam int C_O1VAL = 4;
    localparam int C_O2VAL = 5;
    localparam int C_LOAD  = 8;
    localparam int CFG_W   = 6;
    localparam logic RST_READY = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_DIS   = 6'h01,
        ST_RUN   = 6'h02,
        ST_SLIDE = 6'h04,
        ST_REV   = 6'h08,
        ST_ESTOP = 6'h10,
        ST_RSTW  = 6'h20
    } acd_st_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } acd_wb_req_t;

    typedef struct packed {
        logic        moving;
        logic        inBand;
        logic        forward;
        logic        targetForward;
        logic [31:0] position;
        logic [31:0] followErr;
        logic [31:0] diag;
    } acd_motion_t;

    // Word 0 (offset 0x08) lands in posHi
    typedef struct packed {
        logic [15:0] dec;
        logic [15:0] acc;
        logic [15:0] vel;
        logic [15:0] posLo;
        logic [15:0] posHi;
    } acd_sp_t;

    typedef struct packed {
        logic       axisEnable;
        logic       decelStop;
        logic       analogZero;
        logic       out1;
        logic       out2;
        logic       integralHold;
        logic       launch;
        logic       fromCmdBlock;
        logic       incremental;
        logic [6:0] target;
        logic [6:0] reqTarget;
    } acd_ctrl_t;

    typedef struct packed {
        acd_st_t                       st;
        logic                          ack;
        logic [31:0]                   rdat;
        logic [15:0]                   cmd1;
        logic [15:0]                   cmd2;
        logic [SP13_WORDS-1:0][15:0]   sp13;
        logic [CFG_W-1:0]              cfg;
        logic                          paramValid;
        logic                          prevStart;
        logic                          prevReset;
        logic                          tgtWr;
        logic                          spWr;
        logic [6:0]                    curTarget;
        logic [6:0]                    pendTarget;
        logic                          done;
        logic                          ready;
        logic                          progErr;
        logic                          slideOvr;
        logic [1:0]                    hwSync;
        logic                          hwPrev;
        acd_ctrl_t                     ctrl;
    } acd_regs_t;

endpackage : acd_pkg

// ===== hdl/acd_axis_decoder.sv
// Axis command word decoder with classic Wishbone register slave
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module acd_axis_decoder import acd_pkg::*; (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire acd_wb_req_t wbReq,
    output logic [31:0]      wbDatR,
    output logic             wbAck,
    input  wire logic        hwStartPin,
    input  wire acd_motion_t motion,
    output acd_ctrl_t        ctrl,
    output acd_sp_t          sp13
);

    // ------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------
    acd_regs_t   s;
    acd_regs_t   n;
    logic        req;
    logic        wr;
    logic [15:0] wval;
    logic [31:0] rsrc;
    logic        autoMode;
    logic        slideBit;
    logic [6:0]  tgt;
    logic        swStart;
    logic        hwStart;
    logic        startOk;
    logic        manualErr;
    logic        resetReq;
    logic        tgtOk;
    logic        needRev;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  sel
    );
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge16

    // Issue a move toward target t
    function automatic acd_regs_t fire(
        input acd_regs_t   r,
        input logic [6:0]  t
    );
        acd_regs_t q;
        q = r;
        q.ctrl.launch       = 1'b1;
        q.ctrl.target       = t;
        q.ctrl.fromCmdBlock = (t == TGT_SP13);
        q.ctrl.incremental  = (t == TGT_SP13) & r.cmd1[B_INC13];
        q.curTarget         = t;
        q.done              = 1'b0;
        q.progErr           = 1'b0;
        q.st                = ST_RUN;
        return q;
    endfunction : fire

    // ------------------------------------------------------------
    // Readout selection
    // ------------------------------------------------------------
    always_comb begin
        case (s.cmd1[RSEL_MSB:RSEL_LSB])
            RSEL_POS: begin
                rsrc = motion.position;
            end
            RSEL_FERR: begin
                rsrc = motion.followErr;
            end
            default: begin
                rsrc = motion.diag;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        wval = 16'h0000;
        n.ack = 1'b0;
        n.ctrl.launch = 1'b0;
        n.tgtWr = 1'b0;
        n.spWr = 1'b0;
        n.hwSync = {s.hwSync[0], hwStartPin};
        n.hwPrev = s.hwSync[1];
        n.prevStart = s.cmd1[B_START];
        n.prevReset = s.cmd1[B_RESET];

        // Request decode
        autoMode = s.cmd1[B_AUTO];
        slideBit = s.cmd1[B_SLIDE];
        tgt = s.cmd2[TGT_W-1:0];
        swStart = s.cmd1[B_START]
                & (~s.prevStart
                   | s.tgtWr
                   | (s.spWr & (tgt == TGT_SP13)));
        hwStart = s.hwSync[1] & ~s.hwPrev
                & s.cmd1[B_HWEN] & autoMode
                & (s.cfg[C_ENH] | motion.inBand);
        startOk = (swStart | hwStart) & autoMode;
        manualErr = swStart & ~autoMode;
        resetReq = s.cmd1[B_RESET] & ~s.prevReset;
        tgtOk = (tgt != TGT_NONE) && (tgt != s.curTarget);
        needRev = motion.moving
                & (motion.targetForward != motion.forward);

        // Stop and reset priority
        if (s.cmd1[B_ISTOP]) begin
            n.st = ST_ESTOP;
        end else begin
            case (s.st)
                ST_ESTOP: begin
                    if (s.cmd1[B_RESET]) begin
                        n.st = ST_RSTW;
                        n.ready = 1'b0;
                    end
                end
                ST_RSTW: begin
                    if (!motion.moving) begin
                        n.st = ST_DIS;
                        n.ready = 1'b1;
                        n.paramValid = 1'b0;
                        n.curTarget = TGT_NONE;
                        n.done = 1'b0;
                        n.slideOvr = 1'b0;
                    end
                end
                ST_DIS: begin
                    if (s.paramValid) begin
                        n.st = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (resetReq) begin
                        n.st = ST_RSTW;
                        n.ready = 1'b0;
                    end else if (slideBit) begin
                        n.st = ST_SLIDE;
                        n.done = 1'b0;
                        n.slideOvr = 1'b0;
                    end else if (manualErr) begin
                        n.progErr = 1'b1;
                    end else if (startOk && tgtOk) begin
                        if (needRev) begin
                            n.st = ST_REV;
                            n.pendTarget = tgt;
                        end else begin
                            n = fire(n, tgt);
                        end
                    end
                end
                ST_SLIDE: begin
                    if (resetReq) begin
                        n.st = ST_RSTW;
                        n.ready = 1'b0;
                    end else if (!slideBit) begin
                        n.st = ST_RUN;
                        n.slideOvr = 1'b0;
                    end else if (manualErr) begin
                        n.progErr = 1'b1;
                    end else if (startOk && tgtOk && !s.cfg[C_ENH]) begin
                        n.slideOvr = 1'b1;
                        if (needRev) begin
                            n.st = ST_REV;
                            n.pendTarget = tgt;
                        end else begin
                            n = fire(n, tgt);
                            n.st = ST_SLIDE;
                        end
                    end else if (!s.slideOvr && !motion.moving) begin
                        n.done = 1'b1;
                    end
                end
                ST_REV: begin
                    if (resetReq) begin
                        n.st = ST_RSTW;
                        n.ready = 1'b0;
                    end else if (slideBit && !s.slideOvr) begin
                        n.st = ST_SLIDE;
                        n.done = 1'b0;
                    end else if (!motion.moving) begin
                        n = fire(n, s.pendTarget);
                        if (s.slideOvr) begin
                            n.st = ST_SLIDE;
                        end
                    end
                end
                default: begin
                    n.st = ST_DIS;
                end
            endcase
        end

        // Bus slave, after control so error flags set win
        req = wbReq.cyc & wbReq.stb & ~s.ack;
        wr = req & wbReq.we;
        if (req) begin
            n.ack = 1'b1;
            case (wbReq.adr)
                ADR_CFG: begin
                    n.rdat = {{(32-CFG_W){1'b0}}, s.cfg};
                end
                ADR_STAT: begin
                    n.rdat = {10'h000, s.st, 1'b0, s.curTarget,
                              s.paramValid, motion.moving,
                              s.ctrl.axisEnable, s.st == ST_ESTOP,
                              s.progErr, s.ready,
                              motion.inBand, s.done};
                end
                ADR_RD3: begin
                    n.rdat = {16'h0000, rsrc[31:16]};
                end
                ADR_RD4: begin
                    n.rdat = {16'h0000, rsrc[15:0]};
                end
                default: begin
                    n.rdat = 32'h0000_0000;
                end
            endcase
        end
        if (wr) begin
            case (wbReq.adr)
                ADR_CMD1: begin
                    wval = merge16(s.cmd1, wbReq.dat, wbReq.sel);
                    if (wval[ID_MSB:ID_LSB] == CW1_ID) begin
                        n.cmd1 = wval & CMD1_MASK;
                    end else begin
                        n.progErr = 1'b1;
                    end
                end
                ADR_CMD2: begin
                    wval = merge16(s.cmd2, wbReq.dat, wbReq.sel);
                    n.cmd2 = wval & CMD2_MASK;
                    n.tgtWr = 1'b1;
                end
                ADR_CFG: begin
                    if (wbReq.sel[0]) begin
                        n.cfg = wbReq.dat[CFG_W-1:0];
                    end
                    if (wbReq.sel[1] && wbReq.dat[C_LOAD]) begin
                        n.paramValid = 1'b1;
                    end
                end
                default: begin
                    wval = 16'h0000;
                end
            endcase
            for (int i = 0; i < SP13_WORDS; i++) begin
                if (wbReq.adr == ADR_SP13 + 8'(4 * i)) begin
                    n.sp13[i] = merge16(s.sp13[i], wbReq.dat, wbReq.sel);
                    n.spWr = 1'b1;
                end
            end
        end

        // Outputs toward the loop
        n.ctrl.axisEnable   = (n.st != ST_DIS);
        n.ctrl.decelStop    = (n.st == ST_RSTW)
                            | (n.st == ST_REV)
                            | ((n.st == ST_SLIDE) & ~n.slideOvr);
        n.ctrl.analogZero   = (n.st == ST_ESTOP);
        n.ctrl.out2         = n.cfg[C_O2FLT]
                            ? (n.st == ST_ESTOP)
                            : (n.cfg[C_O2PRG] & n.cfg[C_O2VAL]);
        n.ctrl.out1         = n.cfg[C_O1PRG] & n.cfg[C_O1VAL];
        n.ctrl.integralHold = n.cmd1[B_IDIS];
        n.ctrl.reqTarget    = n.cmd2[TGT_W-1:0];
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s <= '0;
            s.st <= ST_DIS;
            s.ready <= RST_READY;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Port drive
    // ------------------------------------------------------------
    assign wbAck  = s.ack;
    assign wbDatR = s.rdat;
    assign ctrl   = s.ctrl;
    assign sp13   = acd_sp_t'(s.sp13);

endmodule : acd_axis_decoder

// ===== bench/acd_axis_plant.sv
// Behavioural axis plant answering the decoder's control outputs
`timescale 1ns/1ps
module acd_axis_plant import acd_pkg::*; (
    input  wire logic      clk_sys,
    input  wire logic      reset,
    input  wire logic      slow,
    input  wire acd_ctrl_t ctrl,
    output acd_motion_t    motion
);
    logic        moving;
    logic        forward;
    logic        tgtFwd;
    logic [7:0]  cnt;
    logic [6:0]  atTarget;
    logic [31:0] pos;

    assign tgtFwd = ctrl.reqTarget > atTarget;

    // ------------------------------------------------------------
    // Motion: prompt or slow moves, shortened ramp on decel
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            moving   <= 1'b0;
            forward  <= 1'b1;
            cnt      <= 8'h00;
            atTarget <= 7'h00;
            pos      <= 32'h0001_2345;
        end else if (ctrl.analogZero) begin
            moving <= 1'b0;
            cnt    <= 8'h00;
        end else if (ctrl.launch) begin
            moving   <= 1'b1;
            cnt      <= slow ? 8'h28 : 8'h06;
            forward  <= tgtFwd;
            atTarget <= ctrl.target;
        end else if (moving && ctrl.decelStop && cnt > 8'h06) begin
            cnt <= 8'h06;
        end else if (moving) begin
            cnt    <= cnt - 8'h01;
            pos    <= forward ? pos + 32'h1 : pos - 32'h1;
            moving <= cnt != 8'h01;
        end
    end

    assign motion = '{moving: moving, inBand: !moving, forward: forward,
                      targetForward: tgtFwd, position: pos,
                      followErr: {16'h00A5, pos[15:0]}, diag: {pos[15:0], 16'h5A3C}};
endmodule : acd_axis_plant

// ===== bench/acd_axis_decoder_asserts.sv
// Concurrent checks on the axis command word decoder ports
`timescale 1ns/1ps
module acd_axis_decoder_asserts import acd_pkg::*; (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire acd_wb_req_t wbReq,
    input wire logic [31:0] wbDatR,
    input wire logic        wbAck,
    input wire logic        hwStartPin,
    input wire acd_motion_t motion,
    input wire acd_ctrl_t   ctrl,
    input wire acd_sp_t     sp13
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic takeReq;
    logic wrCmd1;
    logic rstWr;
    assign takeReq = wbReq.cyc && wbReq.stb && !wbAck;
    assign wrCmd1  = takeReq && wbReq.we && wbReq.adr == ADR_CMD1 && wbReq.sel == 4'hF
                     && wbReq.dat[15:14] == CW1_ID;
    assign rstWr   = wrCmd1 && wbReq.dat[9] && !wbReq.dat[8];

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_slide;
        wrCmd1 && wbReq.dat[7] && !wbReq.dat[8] && !wbReq.dat[9]
        && ctrl.axisEnable && !ctrl.analogZero;
    endsequence
    sequence s_istop;
        wrCmd1 && wbReq.dat[8];
    endsequence

    ack_take_a:      assert property (takeReq |=> wbAck) else $error("no ack after take");
    ack_pulse_a:     assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
    launch_pulse_a:  assert property (ctrl.launch |=> !ctrl.launch)
        else $error("launch longer than one cycle");
    launch_target_a: assert property (ctrl.launch |-> ctrl.target != TGT_NONE)
        else $error("launch to target zero");
    sp13_source_a:   assert property (ctrl.launch |-> ctrl.fromCmdBlock == (ctrl.target == TGT_SP13))
        else $error("wrong setpoint source");
    slide_decel_a:   assert property (s_slide |-> ##3 ctrl.decelStop && !ctrl.analogZero)
        else $error("slide stop not decelerating");
    istop_set_a:     assert property (s_istop |-> ##3 ctrl.analogZero)
        else $error("immediate stop not applied");
    istop_hold_a:    assert property ($fell(ctrl.analogZero) |-> $past(rstWr, 2)
        || $past(rstWr, 3)) else $error("immediate stop left without reset");
    istop_block_a:   assert property (ctrl.analogZero |-> !ctrl.launch)
        else $error("launch during immediate stop");
    hold_copy_a:     assert property (wrCmd1 && ctrl.axisEnable |-> ##3
        ctrl.integralHold == $past(wbReq.dat[10], 3)) else $error("integral hold wrong");
    reverse_stop_a:  assert property (ctrl.launch |-> !$past(motion.moving)
        || $past(motion.targetForward) == $past(motion.forward))
        else $error("reversal without stop");
endmodule : acd_axis_decoder_asserts

bind acd_axis_decoder acd_axis_decoder_asserts u_chk (.clk_sys(clk_sys), .reset(reset),
    .wbReq(wbReq), .wbDatR(wbDatR), .wbAck(wbAck), .hwStartPin(hwStartPin),
    .motion(motion), .ctrl(ctrl), .sp13(sp13));

// ===== bench/acd_axis_decoder_tb_top.sv
// Self-checking testbench for the axis command word decoder
`timescale 1ns/1ps
module acd_axis_decoder_tb_top import acd_pkg::*;;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        hwStartPin = 1'b0;
    logic        slow = 1'b0;
    acd_wb_req_t wbReq = '0;
    logic [31:0] wbDatR;
    logic [31:0] rd;
    logic [31:0] src;
    logic        wbAck;
    acd_motion_t motion;
    acd_ctrl_t   ctrl;
    acd_sp_t     sp13;
    int          errors = 0;
    int          cmpCount = 0;
    int          launches = 0;

    acd_axis_decoder DUT (.clk_sys(clk_sys), .reset(reset), .wbReq(wbReq), .wbDatR(wbDatR),
        .wbAck(wbAck), .hwStartPin(hwStartPin), .motion(motion), .ctrl(ctrl), .sp13(sp13));
    acd_axis_plant u_plant (.clk_sys(clk_sys), .reset(reset), .slow(slow), .ctrl(ctrl),
        .motion(motion));

    always #4 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (ctrl.launch === 1'b1) launches++;

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        if (errors == 0 && cmpCount > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        for (i = 0; i < 20 && wbAck !== 1'b1; i++) @(posedge clk_sys);
        if (i == 20) begin
            errors++;
            end_of_test();
        end
        rd = wbDatR;
        wbReq <= '0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (4) @(posedge clk_sys);
    endtask : wr

    task automatic waitIdle;
        int i;
        for (i = 0; i < 300 && motion.moving !== 1'b0; i++) @(posedge clk_sys);
        if (i == 300) begin
            errors++;
            end_of_test();
        end
        repeat (4) @(posedge clk_sys);
    endtask : waitIdle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        xfer(1'b0, ADR_STAT, 32'h0);
        check(rd[2], 1'h1);
        check(rd[21:16], 6'h01);
        xfer(1'b0, 8'h30, 32'h0);
        check(rd, 32'h0);
        xfer(1'b0, ADR_CMD1, 32'h0);
        check(rd, 32'h0);
        for (int r = 0; r < 4; r++) begin
            wr(ADR_CMD1, 32'(16'h4004 | (r << 12)));
            src = (r == 0) ? motion.position : (r == 1) ? motion.followErr : motion.diag;
            xfer(1'b0, ADR_RD3, 32'h0);
            check(rd, {16'h0, src[31:16]});
            xfer(1'b0, ADR_RD4, 32'h0);
            check(rd, {16'h0, src[15:0]});
        end
        wr(ADR_CFG, 32'h0116);
        xfer(1'b0, ADR_STAT, 32'h0);
        check(rd[21:16], 6'h02);
        wr(ADR_CMD1, 32'h8004);
        xfer(1'b0, ADR_STAT, 32'h0);
        check(rd[3], 1'h1);
        wr(ADR_CMD2, 32'h5);
        wr(ADR_CMD1, 32'h4004);
        check(launches, 32'h0);
        wr(ADR_CMD1, 32'h4005);
        check(launches, 32'h1);
        check({ctrl.reqTarget, ctrl.target}, 14'h0285);
        waitIdle();
        wr(ADR_CMD1, 32'h4006);
        wr(ADR_CMD2, 32'h8);
        check(launches, 32'h1);
        hwStartPin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        hwStartPin <= 1'b0;
        check(launches, 32'h2);
        waitIdle();
        wr(ADR_CMD1, 32'h400D);
        wr(ADR_CMD2, 32'h0);
        check(launches, 32'h2);
        wr(ADR_CMD1, 32'h4008);
        wr(ADR_CMD1, 32'h4009);
        xfer(1'b0, ADR_STAT, 32'h0);
        check({rd[3], 7'(launches)}, {1'h1, 7'h02});
        wr(ADR_CMD1, 32'h400D);
        for (int i = 0; i < SP13_WORDS; i++) wr(ADR_SP13 + 8'(4 * i), 32'(16'h1111 * (i + 1)));
        for (int i = 0; i < SP13_WORDS; i++) check(sp13[16 * i +: 16], 16'h1111 * (i + 1));
        wr(ADR_CMD2, 32'hD);
        check(launches, 32'h3);
        check({ctrl.fromCmdBlock, ctrl.incremental}, 2'h3);
        waitIdle();
        slow <= 1'b1;
        wr(ADR_CMD2, 32'h2);
        wr(ADR_CMD1, 32'h408D);
        check({ctrl.decelStop, ctrl.analogZero}, 2'h2);
        check(ctrl.out2, 1'h0);
        waitIdle();
        xfer(1'b0, ADR_STAT, 32'h0);
        check(rd[1:0], 2'h3);
        wr(ADR_CMD2, 32'h9);
        check(launches, 32'h5);
        wr(ADR_CMD1, 32'h400D);
        waitIdle();
        wr(ADR_CMD2, 32'hB);
        wr(ADR_CMD2, 32'h4);
        check({ctrl.decelStop, 7'(launches)}, {1'h1, 7'h06});
        waitIdle();
        check(launches, 32'h7);
        waitIdle();
        slow <= 1'b0;
        wr(ADR_CMD1, 32'h440D);
        check(ctrl.integralHold, 1'h1);
        wr(ADR_CMD1, 32'h400D);
        check(ctrl.integralHold, 1'h0);
        wr(ADR_CMD1, 32'h438D);
        check({ctrl.analogZero, ctrl.out2}, 2'h3);
        check(ctrl.decelStop, 1'h0);
        wr(ADR_CMD2, 32'h7);
        wr(ADR_CMD1, 32'h400D);
        check({ctrl.analogZero, 7'(launches)}, {1'h1, 7'h07});
        wr(ADR_CMD1, 32'h420D);
        for (int i = 0; i < 20 && rd[2] !== 1'b1; i++) xfer(1'b0, ADR_STAT, 32'h0);
        check(rd[2], 1'h1);
        check(rd[21:16], 6'h01);
        check({ctrl.axisEnable, ctrl.out1}, 2'h1);
        wr(ADR_CMD1, 32'h400C);
        wr(ADR_CMD1, 32'h400D);
        check(launches, 32'h7);
        wr(ADR_CFG, 32'h0116);
        xfer(1'b0, ADR_STAT, 32'h0);
        check(rd[21:16], 6'h02);
        slow <= 1'b1;
        wr(ADR_CMD2, 32'h3);
        wr(ADR_CMD1, 32'h420D);
        check({ctrl.decelStop, 7'(launches)}, {1'h1, 7'h08});
        waitIdle();
        xfer(1'b0, ADR_STAT, 32'h0);
        check(rd[21:16], 6'h01);
        end_of_test();
    end
endmodule : acd_axis_decoder_tb_top
